// ==== aii_adc_instruction_interface.sv ====
`include "aii_map.svh"
`timescale 1ns/1ps
`default_nettype none

module aii_adc_instruction_interface
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire aii_pkg::aii_word_t i_wb_dat,
  output logic o_wb_ack,
  output aii_pkg::aii_word_t o_wb_dat,
  // Converter core side
  input wire logic i_conv_done,
  input wire aii_pkg::aii_result_t i_conv_result,
  output logic o_conv_start,
  output logic o_cmp_mode,
  output aii_pkg::aii_nib_t o_conv_ctrl_one,
  output aii_pkg::aii_nib_t o_conv_ctrl_two,
  output logic [7:0] o_compare_value,
  // Skip indication to the core
  output logic o_skip
);
  import aii_pkg::*;

  // =====================================================
  // State
  aii_nib_t work_a_reg; // First working register
  aii_nib_t work_b_reg; // Second working register
  aii_nib_t ctrl_one_reg; // conv_ctrl_one
  aii_nib_t ctrl_two_reg; // conv_ctrl_two
  aii_result_t result_reg; // Latched conversion result
  logic [7:0] compare_reg; // Comparator reference
  logic done_reg; // conversion_done_flag
  logic skip_reg; // Last skip decision
  logic busy_reg; // Operation in flight
  logic start_reg; // Start pulse to converter
  logic ack_reg; // Bus acknowledge
  aii_word_t rdat_reg; // Bus read data

  // =====================================================
  // Bus decode
  logic bus_req; // New request, not yet acked
  logic wr_cyc; // Write taken this edge
  logic rd_cyc; // Read taken this edge
  logic lane0; // Low byte lane enabled
  logic lane1; // Second byte lane enabled
  logic instr_wr; // Instruction issued
  aii_op_t op; // Issued instruction word
  logic cmp_mode; // Comparator mode selected

  assign bus_req = i_wb_cyc & i_wb_stb & ~ack_reg;
  assign wr_cyc = bus_req & i_wb_we;
  assign rd_cyc = bus_req & ~i_wb_we;
  assign lane0 = i_wb_sel[0];
  assign lane1 = i_wb_sel[1];
  // Instruction needs both low lanes for all ten bits
  assign instr_wr = wr_cyc & lane0 & lane1
    & (i_wb_adr == `AII_OFS_INSTR);
  assign op = i_wb_dat[9:0];
  assign cmp_mode = ctrl_two_reg[`AII_CMP_MODE_BIT];

  // Decoded instructions
  logic op_hi; // fetch_result_high
  logic op_lo; // fetch_result_low
  logic op_cmpv; // set_compare_value
  logic op_fq1; // fetch_conv_ctrl_one
  logic op_sq1; // store_conv_ctrl_one
  logic op_start; // begin_conversion
  logic op_skip; // skip_on_conversion_done
  logic op_fq2; // fetch_conv_ctrl_two
  logic op_sq2; // store_conv_ctrl_two

  assign op_hi = instr_wr & (op == `AII_OP_FETCH_RESULT_HIGH);
  assign op_lo = instr_wr & (op == `AII_OP_FETCH_RESULT_LOW);
  assign op_cmpv = instr_wr & (op == `AII_OP_SET_COMPARE_VALUE);
  assign op_fq1 = instr_wr & (op == `AII_OP_FETCH_CTRL_ONE);
  assign op_sq1 = instr_wr & (op == `AII_OP_STORE_CTRL_ONE);
  assign op_start = instr_wr & (op == `AII_OP_BEGIN_CONVERSION);
  assign op_skip = instr_wr & (op == `AII_OP_SKIP_ON_DONE);
  assign op_fq2 = instr_wr & (op == `AII_OP_FETCH_CTRL_TWO);
  assign op_sq2 = instr_wr & (op == `AII_OP_STORE_CTRL_TWO);

  // Completion seen only for an operation we started
  logic conv_fin;
  assign conv_fin = i_conv_done & busy_reg;

  // =====================================================
  // Bus acknowledge, one cycle per request
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      ack_reg <= 1'b0;
    end
    else
    begin
      ack_reg <= bus_req;
    end
  end

  // =====================================================
  // Bus read data, captured with the acknowledge
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      rdat_reg <= 32'h0;
    end
    else if (rd_cyc)
    begin
      unique case (i_wb_adr)
        `AII_OFS_WORK_A: rdat_reg <= {28'h0, work_a_reg};
        `AII_OFS_WORK_B: rdat_reg <= {28'h0, work_b_reg};
        `AII_OFS_STATUS:
          rdat_reg <= {28'h0, cmp_mode, busy_reg, skip_reg, done_reg};
        `AII_OFS_CTRL_ONE: rdat_reg <= {28'h0, ctrl_one_reg};
        `AII_OFS_CTRL_TWO: rdat_reg <= {28'h0, ctrl_two_reg};
        `AII_OFS_RESULT: rdat_reg <= {22'h0, result_reg};
        `AII_OFS_COMPARE: rdat_reg <= {24'h0, compare_reg};
        // Instruction port and unmapped read as zero
        default: rdat_reg <= 32'h0;
      endcase
    end
  end

  // =====================================================
  // First working register
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      work_a_reg <= `AII_RST_NIB;
    end
    else if (op_hi)
    begin
      // Comparator mode returns the low byte
      work_a_reg <= cmp_mode ? result_reg[3:0]
        : result_reg[5:2];
    end
    else if (op_lo)
    begin
      work_a_reg <= {result_reg[1:0], 2'b00};
    end
    else if (op_fq1)
    begin
      work_a_reg <= ctrl_one_reg;
    end
    else if (op_fq2)
    begin
      work_a_reg <= ctrl_two_reg;
    end
    else if (wr_cyc & lane0 & (i_wb_adr == `AII_OFS_WORK_A))
    begin
      // Direct software load
      work_a_reg <= i_wb_dat[3:0];
    end
  end

  // =====================================================
  // Second working register
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      work_b_reg <= `AII_RST_NIB;
    end
    else if (op_hi)
    begin
      work_b_reg <= cmp_mode ? result_reg[7:4]
        : result_reg[9:6];
    end
    else if (wr_cyc & lane0 & (i_wb_adr == `AII_OFS_WORK_B))
    begin
      // Direct software load
      work_b_reg <= i_wb_dat[3:0];
    end
  end

  // =====================================================
  // Converter control registers, written only by stores
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      ctrl_one_reg <= `AII_RST_NIB;
      ctrl_two_reg <= `AII_RST_NIB;
    end
    else if (op_sq1)
    begin
      ctrl_one_reg <= work_a_reg;
    end
    else if (op_sq2)
    begin
      ctrl_two_reg <= work_a_reg;
    end
  end

  // =====================================================
  // Comparator reference, loaded only in comparator mode
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      compare_reg <= `AII_RST_COMPARE;
    end
    else if (op_cmpv & cmp_mode)
    begin
      compare_reg <= {work_b_reg, work_a_reg};
    end
  end

  // =====================================================
  // Start pulse and busy tracking
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      start_reg <= 1'b0;
    end
    else
    begin
      // Mode travels on o_cmp_mode with the pulse
      start_reg <= op_start;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      busy_reg <= 1'b0;
    end
    else if (op_start)
    begin
      // A restart abandons any running operation
      busy_reg <= 1'b1;
    end
    else if (conv_fin)
    begin
      busy_reg <= 1'b0;
    end
  end

  // =====================================================
  // Result capture on completion
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      result_reg <= `AII_RST_RESULT;
    end
    else if (conv_fin)
    begin
      result_reg <= i_conv_result;
    end
  end

  // =====================================================
  // Done flag: completion set wins over any clear
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      done_reg <= 1'b0;
    end
    else if (conv_fin)
    begin
      done_reg <= 1'b1;
    end
    else if (op_start)
    begin
      done_reg <= 1'b0;
    end
    else if (op_skip & done_reg)
    begin
      done_reg <= 1'b0;
    end
  end

  // =====================================================
  // Skip decision held for status, pulse for the core
  logic skip_pulse_reg; // One-cycle skip pulse to the core
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      skip_reg <= 1'b0;
      skip_pulse_reg <= 1'b0;
    end
    else
    begin
      skip_pulse_reg <= op_skip & done_reg;
      if (op_skip)
      begin
        skip_reg <= done_reg;
      end
    end
  end

  // =====================================================
  // Outputs, all straight from flip-flops
  assign o_wb_ack = ack_reg;
  assign o_wb_dat = rdat_reg;
  assign o_conv_start = start_reg;
  assign o_cmp_mode = ctrl_two_reg[`AII_CMP_MODE_BIT];
  assign o_conv_ctrl_one = ctrl_one_reg;
  assign o_conv_ctrl_two = ctrl_two_reg;
  assign o_compare_value = compare_reg;
  assign o_skip = skip_pulse_reg;

endmodule : aii_adc_instruction_interface

`default_nettype wire

// ==== aii_chk_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// Port checker
module aii_chk_sva
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Bus
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire aii_pkg::aii_word_t i_wb_dat,
  input wire logic o_wb_ack,
  // Converter side
  input wire logic o_conv_start,
  input wire logic o_cmp_mode,
  input wire aii_pkg::aii_nib_t o_conv_ctrl_one,
  input wire aii_pkg::aii_nib_t o_conv_ctrl_two,
  input wire logic [7:0] o_compare_value,
  input wire logic o_skip
);
  import aii_pkg::*;
  logic tk; // Instruction write taken now
  logic [9:0] op; // Code taken now, else zero
  assign tk = i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack
    && i_wb_adr == 8'h08 && i_wb_sel[1:0] == 2'b11;
  assign op = tk ? i_wb_dat[9:0] : 10'h000;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held too long");
  a_ack_answer: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack
    |=> o_wb_ack) else $error("no ack");
  a_start_cause: assert property (
    o_conv_start == ($past(op) == 10'h29f)) else $error("bad start");
  a_ctrl_one_src: assert property (
    !$stable(o_conv_ctrl_one) |-> $past(op) == 10'h204)
    else $error("ctrl one changed");
  a_ctrl_two_src: assert property (
    !$stable(o_conv_ctrl_two) |-> $past(op) == 10'h205)
    else $error("ctrl two changed");
  a_mode_src: assert property (
    !$stable(o_cmp_mode) |-> $past(op) == 10'h205) else $error("mode bit");
  a_cmp_load: assert property (!$stable(o_compare_value) |->
    $past(op) == 10'h239 && $past(o_cmp_mode)) else $error("ref");
  a_skip_cause: assert property (
    o_skip |-> ($past(op) == 10'h287) ##1 !o_skip) else $error("skip");
  c_start: cover property (o_conv_start);
  c_skip: cover property (o_skip);
  c_ref: cover property (!$stable(o_compare_value));
endmodule : aii_chk_sva
bind aii_adc_instruction_interface aii_chk_sva aii_chk_sva_inst (.i_clk,
  .i_rst_n, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel,
  .i_wb_dat, .o_wb_ack, .o_conv_start, .o_cmp_mode, .o_conv_ctrl_one,
  .o_conv_ctrl_two, .o_compare_value, .o_skip);
`default_nettype wire

// ==== aii_conv_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// Converter model
module aii_conv_model
(
  // Clock and start
  input wire logic i_clk,
  input wire logic i_start,
  // Delay and value set by the bench
  input wire logic [3:0] i_lat,
  input wire logic [9:0] i_val,
  // Completion back to the block
  output logic o_done = 1'b0,
  output logic [9:0] o_result = 10'h155
);
  logic [4:0] cnt_reg = 5'h00; // Cycles left, zero when idle
  // Count down, then pulse done with the result
  always_ff @(posedge i_clk)
  begin
    o_done <= 1'b0;
    if (i_start) // Restart drops the old run
      cnt_reg <= {1'b0, i_lat} + 5'h01;
    else if (cnt_reg != 5'h00)
      cnt_reg <= cnt_reg - 5'h01;
    if (!i_start && cnt_reg == 5'h01)
    begin
      o_done <= 1'b1;
      o_result <= i_val;
    end
    else
      o_result <= ~o_result; // Invalid outside done
  end
endmodule : aii_conv_model
`default_nettype wire

// ==== aii_map.svh ====
`ifndef AII_MAP_SVH
`define AII_MAP_SVH

// =====================================================
// Register byte offsets
`define AII_OFS_WORK_A 8'h00
`define AII_OFS_WORK_B 8'h04
`define AII_OFS_INSTR 8'h08
`define AII_OFS_STATUS 8'h0c
`define AII_OFS_CTRL_ONE 8'h10
`define AII_OFS_CTRL_TWO 8'h14
`define AII_OFS_RESULT 8'h18
`define AII_OFS_COMPARE 8'h1c

// =====================================================
// Status field positions
`define AII_STAT_DONE 0
`define AII_STAT_SKIP 1
`define AII_STAT_BUSY 2
`define AII_STAT_CMP 3

// =====================================================
// Comparator mode select bit inside conv_ctrl_two
`define AII_CMP_MODE_BIT 3

// =====================================================
// Reset values
`define AII_RST_NIB 4'h0
`define AII_RST_RESULT 10'h000
`define AII_RST_COMPARE 8'h00

// =====================================================
// Instruction codes (10-bit)
`define AII_OP_FETCH_RESULT_HIGH 10'h279
`define AII_OP_FETCH_RESULT_LOW 10'h249
`define AII_OP_SET_COMPARE_VALUE 10'h239
`define AII_OP_FETCH_CTRL_ONE 10'h244
`define AII_OP_STORE_CTRL_ONE 10'h204
`define AII_OP_BEGIN_CONVERSION 10'h29f
`define AII_OP_SKIP_ON_DONE 10'h287
`define AII_OP_FETCH_CTRL_TWO 10'h245
`define AII_OP_STORE_CTRL_TWO 10'h205

`endif

// ==== aii_pkg.sv ====
`include "aii_map.svh"

// =====================================================
// Shared types
package aii_pkg;
  // One 4-bit working register
  typedef logic [3:0] aii_nib_t;
  // Instruction word
  typedef logic [9:0] aii_op_t;
  // Converter result
  typedef logic [9:0] aii_result_t;
  // Bus data word
  typedef logic [31:0] aii_word_t;
endpackage : aii_pkg

// ==== test_adc_instruction_interface.sv ====
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// Bench top
module test_adc_instruction_interface;
  import aii_pkg::*;
  logic i_clk = 1'b0, i_rst_n = 1'b0; // Clock, reset
  logic i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0;
  logic [7:0] i_wb_adr = 8'h00;
  logic [3:0] i_wb_sel = 4'h0;
  aii_word_t i_wb_dat = 32'h0, o_wb_dat, rd_val;
  logic o_wb_ack, i_conv_done, o_conv_start, o_cmp_mode, o_skip;
  aii_result_t i_conv_result, val = 10'h2d6;
  aii_nib_t o_conv_ctrl_one, o_conv_ctrl_two;
  logic [7:0] o_compare_value;
  logic [3:0] lat = 4'ha; // Converter delay
  logic sk, st; // Skip and start seen with ack
  int bad_count = 0, comparisons = 0, tick = 0;
  aii_adc_instruction_interface aii_adc_instruction_interface_inst (
    .i_clk, .i_rst_n, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr,
    .i_wb_sel, .i_wb_dat, .o_wb_ack, .o_wb_dat, .i_conv_done,
    .i_conv_result, .o_conv_start, .o_cmp_mode, .o_conv_ctrl_one,
    .o_conv_ctrl_two, .o_compare_value, .o_skip);
  aii_conv_model aii_conv_model_inst (.i_clk, .i_start(o_conv_start),
    .i_lat(lat), .i_val(val), .o_done(i_conv_done),
    .o_result(i_conv_result));
  // =====================================================
  // Clock and timeout
  initial
  begin
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk)
  begin
    tick++;
    if (tick == 20000)
    begin
      bad_count++;
      test_done();
    end
  end
  // =====================================================
  // Shared tasks
  task automatic chk(input aii_word_t s, input aii_word_t e);
    comparisons++;
    if (s !== e)
    begin
      bad_count++;
      $display("MISMATCH %0t saw %h want %h", $time, s, e);
    end
  endtask : chk
  // One classic cycle, held until ack is sampled high at a rising edge
  task automatic wb(input logic w, input logic [7:0] a, input aii_word_t d);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= w;
    i_wb_adr <= a;
    i_wb_dat <= d;
    i_wb_sel <= 4'hf;
    do @(posedge i_clk); while (o_wb_ack !== 1'b1);
    rd_val = o_wb_dat;
    sk = o_skip;
    st = o_conv_start;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    @(posedge i_clk);
  endtask : wb
  task automatic op(input logic [9:0] c);
    wb(1'b1, 8'h08, {22'h0, c});
  endtask : op
  task automatic rd(input logic [7:0] a);
    wb(1'b0, a, 32'h0);
  endtask : rd
  // Poll status until done, bounded
  task automatic wait_done();
    int n;
    n = 0;
    rd(8'h0c);
    while (rd_val[0] !== 1'b1 && n < 40)
    begin
      n++;
      rd(8'h0c);
    end
    chk({31'h0, rd_val[0]}, 32'h1);
  endtask : wait_done
  // =====================================================
  // Scenarios
  task automatic t_regs();
    rd(8'h0c);
    chk(rd_val, 32'h0);
    wb(1'b1, 8'h04, 32'ha);
    wb(1'b1, 8'h20, 32'hf);
    rd(8'h20);
    chk(rd_val, 32'h0);
    rd(8'h04);
    chk(rd_val, 32'ha);
  endtask : t_regs
  task automatic t_ctrl();
    for (int k = 0; k < 2; k++)
    begin
      wb(1'b1, 8'h00, 32'h6 + k);
      op(10'h204 + 10'(k));
      wb(1'b1, 8'h00, 32'h0);
      op(10'h244 + 10'(k));
      rd(8'h00);
      chk(rd_val, 32'h6 + k);
    end
    chk({24'h0, o_conv_ctrl_two, o_conv_ctrl_one}, 32'h76);
  endtask : t_ctrl
  task automatic t_conv();
    op(10'h239);
    chk({24'h0, o_compare_value}, 32'h0);
    op(10'h29f);
    chk({31'h0, st}, 32'h1);
    op(10'h287);
    chk({31'h0, sk}, 32'h0);
    wait_done();
    rd(8'h0c);
    chk(rd_val, 32'h1);
    op(10'h279);
    rd(8'h00);
    chk(rd_val, {28'h0, val[5:2]});
    rd(8'h04);
    chk(rd_val, {28'h0, val[9:6]});
    op(10'h249);
    rd(8'h00);
    chk(rd_val, {28'h0, val[1:0], 2'b00});
    op(10'h287);
    chk({31'h0, sk}, 32'h1);
    op(10'h287);
    chk({31'h0, sk}, 32'h0);
  endtask : t_conv
  task automatic t_cmp();
    wb(1'b1, 8'h00, 32'h8);
    op(10'h205);
    chk({31'h0, o_cmp_mode}, 32'h1);
    wb(1'b1, 8'h00, 32'hc);
    wb(1'b1, 8'h04, 32'h3);
    op(10'h239);
    chk({24'h0, o_compare_value}, 32'h3c);
    val <= 10'h2a5;
    op(10'h29f);
    wait_done();
    op(10'h29f);
    rd(8'h0c);
    chk(rd_val, 32'hc);
    wait_done();
    op(10'h279);
    rd(8'h00);
    chk(rd_val, {28'h0, val[3:0]});
    rd(8'h04);
    chk(rd_val, {28'h0, val[7:4]});
  endtask : t_cmp
  // =====================================================
  // Verdict
  task test_done();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done
  initial
  begin
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    t_regs();
    t_ctrl();
    t_conv();
    t_cmp();
    test_done();
  end
endmodule : test_adc_instruction_interface
`default_nettype wire
